// File: hdl/ssj_pkg.sv
// Constants and types for the shift and short jump execution unit
// How it works
// - Jump target is pc plus two plus displacement
// - Jump opcode is 8'h80 then displacement byte
// - Jump is two bytes, four states
// - Byte left shift carry takes old bit 7
// - Word left shift carry takes old bit 15
// - Byte left shift encoded 3 e r 0
// - Word left shift encoded 3 e r 4
// - Arithmetic right keeps bit 7, carry bit 0
// - Arithmetic right encoded 0 e r 0
package ssj_pkg;
  // ****************************************
  // Opcodes
  // ****************************************
  localparam logic [7:0] SSJ_JUMP_OP = 8'h80;
  localparam logic [7:0] SSJ_PREFIX_OP = 8'ha5;
  localparam logic [7:0] SSJ_SHL_OP = 8'h3e;
  localparam logic [7:0] SSJ_ASR_OP = 8'h0e;
  localparam logic [3:0] SSJ_BYTE_TAIL = 4'h0;
  localparam logic [3:0] SSJ_WORD_TAIL = 4'h4;
  // ****************************************
  // Lengths and state counts
  // ****************************************
  localparam logic [1:0] SSJ_JUMP_BYTES = 2'h2;
  localparam logic [2:0] SSJ_JUMP_STATES = 3'h4;
  localparam logic [1:0] SSJ_SHIFT_BYTES_SRC = 2'h2;
  localparam logic [1:0] SSJ_SHIFT_BYTES_BIN = 2'h3;
  localparam logic [2:0] SSJ_SHIFT_STATES_SRC = 3'h1;
  localparam logic [2:0] SSJ_SHIFT_STATES_BIN = 3'h2;
  localparam logic [15:0] SSJ_PC_RESET = 16'h0000;
  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    SSJ_IDLE = 3'b001,
    SSJ_BUSY = 3'b010,
    SSJ_DONE = 3'b100
  } ssj_state_t;
  typedef enum logic [1:0] {
    SSJ_K_NONE = 2'h0,
    SSJ_K_JUMP = 2'h1,
    SSJ_K_SHIFT = 2'h2
  } ssj_kind_t;
endpackage : ssj_pkg

// File: hdl/ssj_shifter.sv
// Combinational one-bit shifter: left shift of byte or word operands, arithmetic right shift of bytes only
module ssj_shifter (
  // Operand and selects
  input wire logic [15:0] operand,
  input wire logic is_word,
  input wire logic is_right,
  // Result and flags
  output logic [15:0] result,
  output logic carry_out,
  output logic negative_out,
  output logic zero_out
);
  // Shift and flag forming
  always_comb begin
    if (is_right) begin
      result = {8'h00, operand[7], operand[7:1]};
      carry_out = operand[0];
    end else if (is_word) begin
      result = {operand[14:0], 1'b0};
      carry_out = operand[15];
    end else begin
      result = {8'h00, operand[6:0], 1'b0};
      carry_out = operand[7];
    end
    negative_out = is_word ? result[15] : result[7];
    zero_out = is_word ? (result == 16'h0000)
                       : (result[7:0] == 8'h00);
  end
endmodule : ssj_shifter

// File: hdl/ssj_exec.sv
// Execution unit for short relative jump and one-bit register shifts
module ssj_exec (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Instruction in
  input wire logic start,
  input wire logic binary_mode,
  input wire logic [7:0] byte0,
  input wire logic [7:0] byte1,
  input wire logic [7:0] byte2,
  input wire logic [7:0] byte3,
  input wire logic [15:0] pc_in,
  input wire logic [15:0] operand,
  // Flags in
  input wire logic carry_flag_in,
  input wire logic aux_carry_flag_in,
  input wire logic overflow_flag_in,
  input wire logic negative_flag_in,
  input wire logic zero_flag_in,
  // Results out
  output logic busy,
  output logic done,
  output logic illegal,
  output logic pc_load,
  output logic [15:0] pc_out,
  output logic reg_write,
  output logic reg_is_word,
  output logic [3:0] reg_index,
  output logic [15:0] result,
  output logic [1:0] length,
  // Flags out
  output logic carry_flag,
  output logic aux_carry_flag,
  output logic overflow_flag,
  output logic negative_flag,
  output logic zero_flag
);
  typedef struct packed {
    ssj_pkg::ssj_state_t state;
    logic [2:0] count;
    ssj_pkg::ssj_kind_t kind;
    logic illegal;
    logic pc_load;
    logic [15:0] pc;
    logic reg_write;
    logic reg_is_word;
    logic [3:0] reg_index;
    logic [15:0] result;
    logic [1:0] length;
    logic [4:0] flags;
  } ssj_regs_t;

  ssj_regs_t r_reg;
  ssj_regs_t r_next;
  logic [7:0] op_b;
  logic [7:0] reg_b;
  logic has_prefix;
  logic is_jump;
  logic is_shl_b;
  logic is_shl_w;
  logic is_asr_b;
  logic is_shift;
  logic [15:0] sh_result;
  logic sh_carry;
  logic sh_neg;
  logic sh_zero;
  logic [2:0] states;

  // ****************************************
  // Decode
  // ****************************************
  // Strip the escape prefix in binary mode
  always_comb begin
    has_prefix = binary_mode && (byte0 == ssj_pkg::SSJ_PREFIX_OP);
    if (has_prefix) begin
      op_b = byte1;
      reg_b = byte2;
    end else begin
      op_b = byte0;
      reg_b = byte1;
    end
  end

  // Jump needs no prefix in either mode; shifts need it in binary mode
  assign is_jump = (byte0 == ssj_pkg::SSJ_JUMP_OP);
  assign is_shl_b = (binary_mode == has_prefix) &&
    (op_b == ssj_pkg::SSJ_SHL_OP) &&
    (reg_b[3:0] == ssj_pkg::SSJ_BYTE_TAIL);
  assign is_shl_w = (binary_mode == has_prefix) &&
    (op_b == ssj_pkg::SSJ_SHL_OP) &&
    (reg_b[3:0] == ssj_pkg::SSJ_WORD_TAIL);
  assign is_asr_b = (binary_mode == has_prefix) &&
    (op_b == ssj_pkg::SSJ_ASR_OP) &&
    (reg_b[3:0] == ssj_pkg::SSJ_BYTE_TAIL);
  assign is_shift = is_shl_b || is_shl_w || is_asr_b;

  // ****************************************
  // Shifter
  // ****************************************
  ssj_shifter u_shifter (
    .operand(operand),
    .is_word(is_shl_w),
    .is_right(is_asr_b),
    .result(sh_result),
    .carry_out(sh_carry),
    .negative_out(sh_neg),
    .zero_out(sh_zero)
  );

  // State count per instruction
  always_comb begin
    if (is_jump) begin
      states = ssj_pkg::SSJ_JUMP_STATES;
    end else if (binary_mode) begin
      states = ssj_pkg::SSJ_SHIFT_STATES_BIN;
    end else begin
      states = ssj_pkg::SSJ_SHIFT_STATES_SRC;
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  // Results are computed on start and released after the state count
  always_comb begin
    r_next = r_reg;
    r_next.pc_load = 1'b0;
    r_next.reg_write = 1'b0;
    case (r_reg.state)
      ssj_pkg::SSJ_IDLE: begin
        r_next.illegal = 1'b0;
        if (start) begin
          r_next.illegal = !(is_jump || is_shift);
          r_next.flags = {carry_flag_in, aux_carry_flag_in,
            overflow_flag_in, negative_flag_in, zero_flag_in};
          r_next.pc = pc_in + 16'h0002 +
            {{8{byte1[7]}}, byte1};
          r_next.reg_index = reg_b[7:4];
          r_next.reg_is_word = is_shl_w;
          r_next.result = sh_result;
          r_next.length = 2'h0;
          r_next.kind = ssj_pkg::SSJ_K_NONE;
          if (is_jump) begin
            r_next.kind = ssj_pkg::SSJ_K_JUMP;
            r_next.length = ssj_pkg::SSJ_JUMP_BYTES;
          end else if (is_shift) begin
            r_next.kind = ssj_pkg::SSJ_K_SHIFT;
            r_next.flags[4] = sh_carry;
            r_next.flags[1] = sh_neg;
            r_next.flags[0] = sh_zero;
            r_next.length = binary_mode ? ssj_pkg::SSJ_SHIFT_BYTES_BIN
              : ssj_pkg::SSJ_SHIFT_BYTES_SRC;
          end
          if (is_jump || is_shift) begin
            r_next.count = states - 3'h1;
            r_next.state = (states == 3'h1) ? ssj_pkg::SSJ_DONE
              : ssj_pkg::SSJ_BUSY;
          end else begin
            r_next.state = ssj_pkg::SSJ_DONE;
            r_next.count = 3'h0;
          end
        end
      end
      ssj_pkg::SSJ_BUSY: begin
        r_next.count = r_reg.count - 3'h1;
        if (r_reg.count == 3'h1) begin
          r_next.state = ssj_pkg::SSJ_DONE;
        end
      end
      ssj_pkg::SSJ_DONE: begin
        r_next.state = ssj_pkg::SSJ_IDLE;
      end
      default: begin
        r_next.state = ssj_pkg::SSJ_IDLE;
      end
    endcase
    // Commit strobes rise with entry into the done state, chosen by kind,
    // since a source-mode shift has the same length as a jump
    if (r_next.state == ssj_pkg::SSJ_DONE &&
        r_reg.state != ssj_pkg::SSJ_DONE && !r_next.illegal) begin
      r_next.pc_load = (r_next.kind == ssj_pkg::SSJ_K_JUMP);
      r_next.reg_write = (r_next.kind == ssj_pkg::SSJ_K_SHIFT);
    end
  end

  // State register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      r_reg <= '{state: ssj_pkg::SSJ_IDLE, count: 3'h0,
        kind: ssj_pkg::SSJ_K_NONE, illegal: 1'b0,
        pc_load: 1'b0, pc: ssj_pkg::SSJ_PC_RESET, reg_write: 1'b0,
        reg_is_word: 1'b0, reg_index: 4'h0, result: 16'h0000,
        length: 2'h0, flags: 5'h00};
    end else begin
      r_reg <= r_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign busy = (r_reg.state != ssj_pkg::SSJ_IDLE);
  assign done = (r_reg.state == ssj_pkg::SSJ_DONE);
  assign illegal = r_reg.illegal && done;
  assign pc_load = r_reg.pc_load;
  assign pc_out = r_reg.pc;
  assign reg_write = r_reg.reg_write;
  assign reg_is_word = r_reg.reg_is_word;
  assign reg_index = r_reg.reg_index;
  assign result = r_reg.result;
  assign length = r_reg.length;
  assign carry_flag = r_reg.flags[4];
  assign aux_carry_flag = r_reg.flags[3];
  assign overflow_flag = r_reg.flags[2];
  assign negative_flag = r_reg.flags[1];
  assign zero_flag = r_reg.flags[0];

  // ****************************************
  // Checks
  // ****************************************
  jump_target_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (start && !busy && byte0 == ssj_pkg::SSJ_JUMP_OP) |-> ##4 (pc_load &&
      pc_out == $past(pc_in, 4) + 16'h0002 +
      {{8{$past(byte1[7], 4)}}, $past(byte1, 4)}))
    else $error("jump target wrong");
  jump_states_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (start && !busy && byte0 == ssj_pkg::SSJ_JUMP_OP) |->
      ##1 (!done) [*3] ##1 done)
    else $error("jump state count wrong");
  jump_flags_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (start && !busy && byte0 == ssj_pkg::SSJ_JUMP_OP) |-> ##4
      ({carry_flag, aux_carry_flag, overflow_flag, negative_flag,
      zero_flag} == $past({carry_flag_in, aux_carry_flag_in,
      overflow_flag_in, negative_flag_in, zero_flag_in}, 4)))
    else $error("jump changed flags");
  shl_byte_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (start && !busy && !binary_mode && byte0 == ssj_pkg::SSJ_SHL_OP &&
      byte1[3:0] == ssj_pkg::SSJ_BYTE_TAIL) |-> ##1 (reg_write &&
      result == {8'h00, $past(operand[6:0]), 1'b0} &&
      carry_flag == $past(operand[7])))
    else $error("byte left shift wrong");
  shl_word_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (start && !busy && !binary_mode && byte0 == ssj_pkg::SSJ_SHL_OP &&
      byte1[3:0] == ssj_pkg::SSJ_WORD_TAIL) |-> ##1 (reg_write &&
      reg_is_word && result == {$past(operand[14:0]), 1'b0} &&
      carry_flag == $past(operand[15])))
    else $error("word left shift wrong");
  asr_byte_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (start && !busy && !binary_mode && byte0 == ssj_pkg::SSJ_ASR_OP &&
      byte1[3:0] == ssj_pkg::SSJ_BYTE_TAIL) |-> ##1 (reg_write &&
      result == {8'h00, $past(operand[7]), $past(operand[7:1])} &&
      carry_flag == $past(operand[0])))
    else $error("arith right shift wrong");
  prefix_len_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (start && !busy && binary_mode && byte0 == ssj_pkg::SSJ_PREFIX_OP &&
      byte1 == ssj_pkg::SSJ_SHL_OP &&
      byte2[3:0] == ssj_pkg::SSJ_BYTE_TAIL) |-> ##1 !done ##1
      (done && reg_write && length == ssj_pkg::SSJ_SHIFT_BYTES_BIN))
    else $error("binary mode shift timing wrong");
  shift_aux_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (start && !busy) |=> (aux_carry_flag == $past(aux_carry_flag_in) &&
      overflow_flag == $past(overflow_flag_in)))
    else $error("aux carry or overflow altered");
  shift_nz_a: assert property (
    @(posedge clk) disable iff (!resetn)
    reg_write |-> (zero_flag == (reg_is_word ? result == 16'h0000
      : result[7:0] == 8'h00) &&
      negative_flag == (reg_is_word ? result[15] : result[7])))
    else $error("shift flags wrong");
  strobe_excl_a: assert property (
    @(posedge clk) disable iff (!resetn)
    pc_load |-> (done && !reg_write && !illegal))
    else $error("pc load strobe misplaced");
endmodule : ssj_exec

// File: bench/tb_top.sv
// Self-checking bench for the shift and short jump execution unit
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // Signals
  // ****************************************
  logic clk, resetn, start, binary_mode;
  logic [7:0] byte0, byte1, byte2, byte3;
  logic [15:0] pc_in, operand, pc_out, result;
  logic carry_flag_in, aux_carry_flag_in, overflow_flag_in;
  logic negative_flag_in, zero_flag_in;
  logic busy, done, illegal, pc_load, reg_write, reg_is_word;
  logic [3:0] reg_index;
  logic [1:0] length;
  logic carry_flag, aux_carry_flag, overflow_flag, negative_flag, zero_flag;
  int mismatches, total_checks;

  ssj_exec dut (.clk(clk), .resetn(resetn), .start(start),
    .binary_mode(binary_mode), .byte0(byte0), .byte1(byte1), .byte2(byte2),
    .byte3(byte3), .pc_in(pc_in), .operand(operand),
    .carry_flag_in(carry_flag_in), .aux_carry_flag_in(aux_carry_flag_in),
    .overflow_flag_in(overflow_flag_in), .negative_flag_in(negative_flag_in),
    .zero_flag_in(zero_flag_in), .busy(busy), .done(done), .illegal(illegal),
    .pc_load(pc_load), .pc_out(pc_out), .reg_write(reg_write),
    .reg_is_word(reg_is_word), .reg_index(reg_index), .result(result),
    .length(length), .carry_flag(carry_flag), .aux_carry_flag(aux_carry_flag),
    .overflow_flag(overflow_flag), .negative_flag(negative_flag),
    .zero_flag(zero_flag));

  // Core clock, 100 ns period
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task conclude;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude

  // Compare seen against expected value
  task chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Hand one instruction over and count cycles until completion
  task issue(input logic bm, input logic [7:0] b0, input logic [7:0] b1,
      input logic [7:0] b2, input logic [15:0] pc, input logic [15:0] op,
      input logic [4:0] fl, output int cyc);
    @(posedge clk);
    start <= 1'b1;
    binary_mode <= bm;
    byte0 <= b0;
    byte1 <= b1;
    byte2 <= b2;
    pc_in <= pc;
    operand <= op;
    {carry_flag_in, aux_carry_flag_in, overflow_flag_in, negative_flag_in,
      zero_flag_in} <= fl;
    @(posedge clk);
    start <= 1'b0;
    cyc = 1;
    while (cyc < 20) begin
      #1;
      if (done === 1'b1) break;
      chk(busy, 1'b1);
      @(posedge clk);
      cyc++;
    end
    if (done !== 1'b1) begin
      mismatches++;
      $display("[ERR] %0t no completion", $time);
      conclude();
    end
  endtask : issue

  // Pulses drop and the unit idles one cycle after completion
  task tail;
    @(posedge clk);
    #1;
    chk(done, 1'b0);
    chk(pc_load | reg_write | illegal, 1'b0);
  endtask : tail

  task do_jump(input logic bm, input logic [15:0] pc, input logic [7:0] d,
      input logic [15:0] exp);
    int cyc;
    issue(bm, ssj_pkg::SSJ_JUMP_OP, d, 8'h00, pc, 16'h1234, 5'b10011, cyc);
    chk(16'(cyc), 16'h0004);
    chk(16'(length), 16'h0002);
    chk(pc_load, 1'b1);
    chk(pc_out, exp);
    chk(reg_write | illegal, 1'b0);
    chk({carry_flag, aux_carry_flag, overflow_flag, negative_flag,
      zero_flag}, 5'b10011);
    tail();
  endtask : do_jump

  task do_shift(input logic bm, input logic [7:0] opc, input logic [3:0] tl,
      input logic [15:0] op, input logic [15:0] exp, input logic ecy);
    int cyc;
    logic w;
    w = (tl == ssj_pkg::SSJ_WORD_TAIL);
    if (bm) begin
      issue(1'b1, ssj_pkg::SSJ_PREFIX_OP, opc, {4'h5, tl}, 16'h0200, op,
        5'b01101, cyc);
    end else begin
      issue(1'b0, opc, {4'h5, tl}, 8'h00, 16'h0200, op, 5'b01101, cyc);
    end
    chk(16'(cyc), bm ? 16'h0002 : 16'h0001);
    chk(16'(length), bm ? 16'h0003 : 16'h0002);
    chk({reg_write, pc_load, illegal, reg_is_word}, {3'b100, w});
    chk(reg_index, 4'h5);
    chk(result, exp);
    chk(carry_flag, ecy);
    chk(negative_flag, w ? exp[15] : exp[7]);
    chk(zero_flag, exp == 16'h0000);
    chk({aux_carry_flag, overflow_flag}, 2'b11);
    tail();
  endtask : do_shift

  // ****************************************
  // Scenarios
  // ****************************************
  task sc_jumps;
    do_jump(1'b0, 16'h0100, 8'h21, 16'h0123);
    do_jump(1'b1, 16'h1000, 8'h80, 16'h0f82);
    do_jump(1'b1, 16'hffff, 8'h7f, 16'h0080);
  endtask : sc_jumps

  task sc_left_shifts;
    do_shift(1'b0, ssj_pkg::SSJ_SHL_OP, 4'h0, 16'habc5, 16'h008a,
      1'b1);
    do_shift(1'b1, ssj_pkg::SSJ_SHL_OP, 4'h0, 16'h0040, 16'h0080,
      1'b0);
    do_shift(1'b1, ssj_pkg::SSJ_SHL_OP, 4'h4, 16'h8001, 16'h0002,
      1'b1);
    do_shift(1'b0, ssj_pkg::SSJ_SHL_OP, 4'h4, 16'h4000, 16'h8000,
      1'b0);
  endtask : sc_left_shifts

  task sc_right_shifts;
    do_shift(1'b0, ssj_pkg::SSJ_ASR_OP, 4'h0, 16'h00c5, 16'h00e2,
      1'b1);
    do_shift(1'b1, ssj_pkg::SSJ_ASR_OP, 4'h0, 16'hff01, 16'h0000,
      1'b1);
    do_shift(1'b0, ssj_pkg::SSJ_ASR_OP, 4'h0, 16'h0042, 16'h0021,
      1'b0);
  endtask : sc_right_shifts

  // Prefix missing in binary mode, present in source mode
  task sc_illegal;
    int cyc;
    issue(1'b1, ssj_pkg::SSJ_SHL_OP, 8'h50, 8'h00, 16'h0300, 16'h0011,
      5'b00000, cyc);
    chk(16'(cyc), 16'h0001);
    chk({illegal, reg_write, pc_load}, 3'b100);
    tail();
    issue(1'b0, ssj_pkg::SSJ_PREFIX_OP, ssj_pkg::SSJ_ASR_OP, 8'h50,
      16'h0300, 16'h0011, 5'b00000, cyc);
    chk(16'(cyc), 16'h0001);
    chk({illegal, reg_write, pc_load}, 3'b100);
    tail();
  endtask : sc_illegal

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    mismatches = 0;
    total_checks = 0;
    resetn = 1'b0;
    start = 1'b0;
    binary_mode = 1'b0;
    {byte0, byte1, byte2, byte3} = 32'h0000_0000;
    pc_in = 16'h0000;
    operand = 16'h0000;
    {carry_flag_in, aux_carry_flag_in, overflow_flag_in, negative_flag_in,
      zero_flag_in} = 5'b00000;
    repeat (11) @(posedge clk);
    #1;
    chk({busy, done, pc_load, reg_write}, 4'h0);
    @(posedge clk);
    resetn <= 1'b1;
    sc_jumps();
    sc_left_shifts();
    sc_right_shifts();
    sc_illegal();
    conclude();
  end
endmodule : tb_top
